/* File: pkg/power_mode_pkg.sv */
// Package for the power mode manager: register map, fields, states, carriers
package power_mode_pkg;
	// Wishbone word offsets (byte addresses)
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] CLKCTRL_OFFSET = 4'h8;
	localparam logic [3:0] WAKE_OFFSET = 4'hc;
	// Control register fields
	localparam int SAVE_BIT = 0;
	localparam int IDLE_BIT = 1;
	localparam int HALT_BIT = 2;
	localparam int WAIT_GATE_BIT = 3;
	localparam int MAIN_OFF_BIT = 4;
	localparam int PLL_OFF_BIT = 5;
	localparam logic [7:0] CTRL_WMASK = 8'h3f;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Status register fields
	localparam int LOW_OK_BIT = 0;
	localparam int MAIN_OK_BIT = 1;
	localparam int PLL_OK_BIT = 2;
	// Clock control register: pll_powerdown
	localparam int PLL_PWD_BIT = 0;
	localparam logic [7:0] STATUS_UPPER_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_ACTIVE,
		ST_TO_SAVE,
		ST_SAVE,
		ST_TO_ACTIVE,
		ST_IDLE,
		ST_HALT,
		ST_WAKE_MAIN,
		ST_WAKE_PLL
	} mode_type;

	// Clock-source health, synchronised
	typedef struct packed {
		logic low_osc_ok;
		logic main_osc_ok;
		logic pll_stable;
	} osc_status_type;

	// Clock gating outputs
	typedef struct packed {
		logic sys_clk_run;
		logic sys_clk_slow;
		logic slow_clk_run;
		logic main_osc_en;
		logic pll_en;
	} clk_ctrl_type;
endpackage : power_mode_pkg

/* File: hw/power_manager.sv */
// Power mode manager: mode state machine, clock gating and Wishbone registers
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module power_manager (
	input wire logic sys_clk, // 100 MHz system clock
	input wire logic rst, // Async reset, active high
	input wire logic clk_en, // Freezes all state when low
	input wire logic [3:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	input wire logic wb_we_i, // Write enable
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	output logic wb_ack_o, // Acknowledge
	input wire logic cpu_wait, // CPU executes WAIT (one-cycle pulse)
	input wire logic wake_req, // Maskable wake request, asynchronous
	input wire logic nmi_req, // Non-maskable wake request, asynchronous
	input wire logic int_ack, // Interrupt acknowledge cycle
	input wire logic low_osc_stable, // Slow oscillator stable, asynchronous
	input wire logic main_osc_stable, // Main oscillator stable, asynchronous
	input wire logic pll_lock, // PLL locked, asynchronous
	output power_mode_pkg::clk_ctrl_type clk_ctrl, // Clock gating controls
	output logic wake_pending // Latched wake-up event
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
		end else if (clk_en) begin
			sync1_r <= {nmi_req, wake_req, pll_lock, main_osc_stable, low_osc_stable};
			sync2_r <= sync1_r;
		end
	end

	logic [7:0] ctrl_r;
	logic pll_pwd_r;
	power_mode_pkg::mode_type state_r;
	power_mode_pkg::mode_type state_nxt;
	power_mode_pkg::osc_status_type osc;
	logic pll_en;
	logic wake_r;
	logic nmi_prev_r;
	logic wake_prev_r;
	logic wake_evt;

	// PLL disabled reads stable, so it drops out of the qualification
	always_comb begin
		osc.low_osc_ok = sync2_r[0];
		osc.main_osc_ok = sync2_r[1];
		osc.pll_stable = sync2_r[2] | ~pll_en;
	end

	// ------------------------------------------------------------
	// Wake-up latch
	// ------------------------------------------------------------
	// Edge detect so a held request does not re-wake after acknowledge
	assign wake_evt = (sync2_r[3] & ~wake_prev_r) | (sync2_r[4] & ~nmi_prev_r);
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_prev_r <= 1'b0;
			nmi_prev_r <= 1'b0;
			wake_r <= 1'b0;
		end else if (clk_en) begin
			wake_prev_r <= sync2_r[3];
			nmi_prev_r <= sync2_r[4];
			// Set wins over acknowledge
			if (wake_evt)
				wake_r <= 1'b1;
			else if (int_ack)
				wake_r <= 1'b0;
		end
	end
	assign wake_pending = wake_r;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic ack_r;
	logic bus_wr;
	assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];
	function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
		hit = (adr == off);
	endfunction : hit
	logic ctrl_wr;
	assign ctrl_wr = bus_wr & hit(wb_adr_i, power_mode_pkg::CTRL_OFFSET);

	// ------------------------------------------------------------
	// Mode state machine
	// ------------------------------------------------------------
	logic in_save_like;
	logic low_power;
	logic wait_held_r;
	logic wait_seen;

	// Gated entry target, halt over idle over save
	function automatic power_mode_pkg::mode_type gated_target(input logic [7:0] c);
		if (c[power_mode_pkg::HALT_BIT])
			gated_target = power_mode_pkg::ST_HALT;
		else if (c[power_mode_pkg::IDLE_BIT])
			gated_target = power_mode_pkg::ST_IDLE;
		else if (c[power_mode_pkg::SAVE_BIT])
			gated_target = power_mode_pkg::ST_SAVE;
		else
			gated_target = power_mode_pkg::ST_ACTIVE;
	endfunction : gated_target

	// A WAIT that meets a bad slow oscillator is held, not lost
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_held_r <= 1'b0;
		end else if (clk_en) begin
			if (state_r != power_mode_pkg::ST_ACTIVE || !ctrl_r[power_mode_pkg::WAIT_GATE_BIT])
				wait_held_r <= 1'b0;
			else if (cpu_wait && !osc.low_osc_ok)
				wait_held_r <= 1'b1;
			else if (osc.low_osc_ok)
				wait_held_r <= 1'b0;
		end
	end
	assign wait_seen = cpu_wait | wait_held_r;
	assign low_power = (state_r == power_mode_pkg::ST_SAVE) || (state_r == power_mode_pkg::ST_IDLE) ||
		(state_r == power_mode_pkg::ST_HALT);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			power_mode_pkg::ST_ACTIVE: begin
				if (ctrl_r[power_mode_pkg::WAIT_GATE_BIT]) begin
					if (wait_seen && osc.low_osc_ok)
						state_nxt = gated_target(ctrl_r);
				end else if (ctrl_r[power_mode_pkg::SAVE_BIT]) begin
					state_nxt = power_mode_pkg::ST_TO_SAVE;
				end
			end
			// Immediate switch parks here until the slow oscillator is good
			power_mode_pkg::ST_TO_SAVE: begin
				if (!ctrl_r[power_mode_pkg::SAVE_BIT])
					state_nxt = power_mode_pkg::ST_ACTIVE;
				else if (osc.low_osc_ok)
					state_nxt = power_mode_pkg::ST_SAVE;
			end
			power_mode_pkg::ST_SAVE: begin
				if (wake_evt)
					state_nxt = power_mode_pkg::ST_WAKE_MAIN;
				else if (!ctrl_r[power_mode_pkg::SAVE_BIT])
					state_nxt = power_mode_pkg::ST_TO_ACTIVE;
			end
			power_mode_pkg::ST_TO_ACTIVE: begin
				if (osc.main_osc_ok && osc.pll_stable)
					state_nxt = power_mode_pkg::ST_ACTIVE;
			end
			power_mode_pkg::ST_IDLE, power_mode_pkg::ST_HALT: begin
				if (wake_evt)
					state_nxt = power_mode_pkg::ST_WAKE_MAIN;
			end
			power_mode_pkg::ST_WAKE_MAIN: begin
				if (osc.main_osc_ok)
					state_nxt = power_mode_pkg::ST_WAKE_PLL;
			end
			power_mode_pkg::ST_WAKE_PLL: begin
				if (osc.pll_stable)
					state_nxt = power_mode_pkg::ST_ACTIVE;
			end
		endcase
	end
	assign in_save_like = (state_r == power_mode_pkg::ST_SAVE) || (state_r == power_mode_pkg::ST_TO_ACTIVE);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			state_r <= power_mode_pkg::ST_ACTIVE;
		else if (clk_en)
			state_r <= state_nxt;
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Save bit is stored as written; the read view hides the pending
	// switch and holds 1 on the way back to Active.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= power_mode_pkg::CTRL_RESET;
		end else if (clk_en) begin
			if (ctrl_wr) begin
				ctrl_r[7:1] <= wb_dat_i[7:1] & power_mode_pkg::CTRL_WMASK[7:1];
				// A 0 in Save must reach the state machine, or Save is never left
				ctrl_r[power_mode_pkg::SAVE_BIT] <= wb_dat_i[power_mode_pkg::SAVE_BIT];
			end
			// Hardware wake clears mode and disable bits; halt waits for the oscillator
			if (state_r == power_mode_pkg::ST_WAKE_MAIN) begin
				ctrl_r[power_mode_pkg::MAIN_OFF_BIT] <= 1'b0;
				ctrl_r[power_mode_pkg::IDLE_BIT] <= 1'b0;
				ctrl_r[power_mode_pkg::SAVE_BIT] <= 1'b0;
				if (osc.main_osc_ok)
					ctrl_r[power_mode_pkg::HALT_BIT] <= 1'b0;
			end
			if (state_r == power_mode_pkg::ST_WAKE_PLL)
				ctrl_r[power_mode_pkg::PLL_OFF_BIT] <= 1'b0;
			if (state_r == power_mode_pkg::ST_TO_ACTIVE && state_nxt == power_mode_pkg::ST_ACTIVE)
				ctrl_r[power_mode_pkg::SAVE_BIT] <= 1'b0;
		end
	end

	// Read view: save bit with gate clear shows 1 only once Save is reached
	logic [7:0] ctrl_view;
	always_comb begin
		ctrl_view = ctrl_r;
		if (!ctrl_r[power_mode_pkg::WAIT_GATE_BIT] &&
			(state_r == power_mode_pkg::ST_ACTIVE || state_r == power_mode_pkg::ST_TO_SAVE))
			ctrl_view[power_mode_pkg::SAVE_BIT] = 1'b0;
		if (in_save_like)
			ctrl_view[power_mode_pkg::SAVE_BIT] = 1'b1;
	end

	// ------------------------------------------------------------
	// Clock control register and clock gating
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			pll_pwd_r <= 1'b0;
		else if (clk_en && bus_wr && hit(wb_adr_i, power_mode_pkg::CLKCTRL_OFFSET))
			pll_pwd_r <= wb_dat_i[power_mode_pkg::PLL_PWD_BIT];
	end

	// Halt stops the system clock one cycle before the oscillators
	logic halt_sys_off_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			halt_sys_off_r <= 1'b0;
		else if (clk_en)
			halt_sys_off_r <= (state_r == power_mode_pkg::ST_HALT);
	end

	logic main_en;
	always_comb begin
		// Off bits only bite after the low-power mode is entered
		main_en = 1'b1;
		pll_en = ~pll_pwd_r;
		if (low_power && state_r != power_mode_pkg::ST_HALT) begin
			if (ctrl_r[power_mode_pkg::MAIN_OFF_BIT])
				main_en = 1'b0;
			if (ctrl_r[power_mode_pkg::PLL_OFF_BIT])
				pll_en = 1'b0;
		end
		if (state_r == power_mode_pkg::ST_HALT && halt_sys_off_r) begin
			main_en = 1'b0;
			pll_en = 1'b0;
		end
		if (state_r == power_mode_pkg::ST_WAKE_MAIN && ctrl_r[power_mode_pkg::PLL_OFF_BIT])
			pll_en = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clk_ctrl <= '{sys_clk_run: 1'b1, sys_clk_slow: 1'b0, slow_clk_run: 1'b1, main_osc_en: 1'b1,
				pll_en: 1'b1};
		end else if (clk_en) begin
			clk_ctrl.sys_clk_run <= (state_r != power_mode_pkg::ST_IDLE) && (state_r != power_mode_pkg::ST_HALT);
			// Wake stays on the slow clock until main and PLL are both good
			clk_ctrl.sys_clk_slow <= in_save_like || (state_r == power_mode_pkg::ST_WAKE_MAIN) ||
				(state_r == power_mode_pkg::ST_WAKE_PLL);
			clk_ctrl.slow_clk_run <= (state_r != power_mode_pkg::ST_HALT);
			clk_ctrl.main_osc_en <= main_en;
			clk_ctrl.pll_en <= pll_en;
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave: one wait state, unmapped reads zero
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			wb_dat_o <= 32'h0000_0000;
			unique case (wb_adr_i)
				power_mode_pkg::CTRL_OFFSET: wb_dat_o[7:0] <= ctrl_view;
				power_mode_pkg::STATUS_OFFSET: wb_dat_o[7:0] <= {power_mode_pkg::STATUS_UPPER_RESET[7:3],
					osc.pll_stable, osc.main_osc_ok, osc.low_osc_ok};
				power_mode_pkg::CLKCTRL_OFFSET: wb_dat_o[0] <= pll_pwd_r;
				power_mode_pkg::WAKE_OFFSET: wb_dat_o[0] <= wake_r;
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
	assign wb_ack_o = ack_r;
endmodule : power_manager

/* File: verification/power_manager_monitor.sv */
// Port checker for the power mode manager
`timescale 1ns/100ps
module power_manager_monitor (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Async reset
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_ack_o, // Bus acknowledge
	input wire logic wake_req, // Maskable wake
	input wire logic int_ack, // Interrupt acknowledge
	input wire logic low_osc_stable, // Slow oscillator ok
	input wire logic main_osc_stable, // Main oscillator ok
	input wire power_mode_pkg::clk_ctrl_type clk_ctrl, // Clock gating
	input wire logic wake_pending // Latched wake
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic on_main;
	assign on_main = clk_ctrl.sys_clk_run && !clk_ctrl.sys_clk_slow;
	sequence clk_stopped;
		$fell(clk_ctrl.sys_clk_run);
	endsequence
	sequence osc_down;
		!clk_ctrl.main_osc_en && !clk_ctrl.pll_en;
	endsequence
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_main_on_active: assert property (on_main |-> clk_ctrl.main_osc_en) else $error("osc off in active");
	a_active_needs_main: assert property ($rose(on_main) |-> $past(main_osc_stable, 2)) else $error("early active");
	a_leave_needs_low: assert property ($fell(on_main) |-> $past(low_osc_stable, 2)) else $error("slow osc bad");
	a_halt_order: assert property (clk_stopped |-> ##1 osc_down) else $error("oscillators left on");
	a_pll_after_main: assert property ($rose(clk_ctrl.pll_en) |-> clk_ctrl.main_osc_en && $past(main_osc_stable, 2))
		else $error("pll before main");
	a_wake_latched: assert property (wake_pending && !int_ack |=> wake_pending) else $error("wake lost");
	a_wake_caught: assert property ($rose(wake_req) |-> ##[1:4] wake_pending) else $error("wake missed");
	a_wake_returns: assert property ($rose(wake_pending) |-> ##[1:200] on_main) else $error("no return");
endmodule : power_manager_monitor

bind power_manager power_manager_monitor chk (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wake_req, .int_ack,
	.low_osc_stable, .main_osc_stable, .clk_ctrl, .wake_pending);

/* File: verification/cpu_wake_model.sv */
// Model of the CPU interrupt side, wake sources and clock sources
`timescale 1ns/100ps
module cpu_wake_model (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Async reset
	input wire logic fire_wake, // Raise maskable wake
	input wire logic fire_nmi, // Raise non-maskable wake
	input wire logic low_en, // Slow oscillator running
	input wire power_mode_pkg::clk_ctrl_type clk_ctrl, // Clock gating
	input wire logic wake_pending, // Latched wake
	output logic wake_req, // Maskable wake level
	output logic nmi_req, // Non-maskable wake level
	output logic int_ack, // Acknowledge cycle
	output logic low_osc_stable, // Slow oscillator ok
	output logic main_osc_stable, // Main oscillator ok
	output logic pll_lock // PLL locked
);
	logic [3:0] main_cnt_r;
	logic [3:0] pll_cnt_r;
	// Startup times arbitrary, long enough to expose missing waits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			main_cnt_r <= 4'h0;
			pll_cnt_r <= 4'h0;
		end else begin
			main_cnt_r <= !clk_ctrl.main_osc_en ? 4'h0 : main_cnt_r + {3'h0, !main_osc_stable};
			pll_cnt_r <= !(clk_ctrl.pll_en && main_osc_stable) ? 4'h0 : pll_cnt_r + {3'h0, !pll_lock};
		end
	end
	assign main_osc_stable = main_cnt_r == 4'hf;
	assign pll_lock = pll_cnt_r == 4'hf;
	assign low_osc_stable = low_en;
	// Handler runs only on restored clocks, so acknowledge waits for them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_req <= 1'b0;
			nmi_req <= 1'b0;
			int_ack <= 1'b0;
		end else begin
			int_ack <= wake_pending && !int_ack && clk_ctrl.sys_clk_run && !clk_ctrl.sys_clk_slow;
			wake_req <= fire_wake || (wake_req && !int_ack);
			nmi_req <= fire_nmi || (nmi_req && !int_ack);
		end
	end
endmodule : cpu_wake_model

/* File: verification/test_power_manager.sv */
// Self-checking bench for the power mode manager
`timescale 1ns/100ps
module test_power_manager;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, cpu_wait = 1'b0;
	logic fire_wake = 1'b0, fire_nmi = 1'b0, low_en = 1'b1;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, wake_req, nmi_req, int_ack, low_osc_stable, main_osc_stable, pll_lock, wake_pending;
	power_mode_pkg::clk_ctrl_type clk_ctrl;
	int miscompares = 0, n_tests = 0;
	logic [7:0] q;
	always #5 sys_clk = ~sys_clk;
	power_manager uut (.sys_clk, .rst, .clk_en(1'b1), .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
		.wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpu_wait, .wake_req, .nmi_req, .int_ack, .low_osc_stable,
		.main_osc_stable, .pll_lock, .clk_ctrl, .wake_pending);
	cpu_wake_model far_side (.sys_clk, .rst, .fire_wake, .fire_nmi, .low_en, .clk_ctrl, .wake_pending,
		.wake_req, .nmi_req, .int_ack, .low_osc_stable, .main_osc_stable, .pll_lock);
	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : check
	task automatic timeout(input string what);
		$display("wrong value %s expected done seen timeout", what);
		miscompares++;
		report_and_stop();
	endtask : timeout
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= 4'hf;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1) begin
			if (n == 20) timeout("bus ack");
			@(posedge sys_clk);
			n++;
		end
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus
	task automatic poll(input logic [3:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		bus(a, 1'b0, 8'h00);
		while (q !== exp) begin
			if (n == 100) timeout("register poll");
			bus(a, 1'b0, 8'h00);
			n++;
		end
		check("polled register", exp, q);
	endtask : poll
	task automatic wait_clk(input logic [4:0] mask, input logic [4:0] exp);
		int n;
		n = 0;
		while ((clk_ctrl & mask) !== exp) begin
			if (n == 300) timeout("clock gating");
			@(posedge sys_clk);
			n++;
		end
		check("clock gating", {3'h0, exp}, {3'h0, clk_ctrl & mask});
	endtask : wait_clk
	task automatic pulse(input int which);
		@(posedge sys_clk);
		cpu_wait <= (which == 0);
		fire_wake <= (which == 1);
		fire_nmi <= (which == 2);
		@(posedge sys_clk);
		{cpu_wait, fire_wake, fire_nmi} <= 3'h0;
	endtask : pulse
	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic reset_values;
		poll(4'h4, 8'h07);
		bus(4'h0, 1'b0, 8'h00);
		check("control reset", 8'h00, q);
		bus(4'h4, 1'b1, 8'hf8);
		bus(4'h2, 1'b1, 8'h3f);
		bus(4'h4, 1'b0, 8'h00);
		check("status read only", 8'h07, q);
		bus(4'h2, 1'b0, 8'h00);
		check("unmapped read", 8'h00, q);
		bus(4'h0, 1'b0, 8'h00);
		check("control after stray writes", 8'h00, q);
	endtask : reset_values
	task automatic immediate_save;
		bus(4'h0, 1'b1, 8'h01);
		poll(4'h0, 8'h01);
		wait_clk(5'h1f, 5'h1f);
		bus(4'h0, 1'b1, 8'h31);
		wait_clk(5'h1f, 5'h1c);
		poll(4'h4, 8'h05);
		bus(4'h0, 1'b1, 8'h21);
		poll(4'h4, 8'h07);
		bus(4'h0, 1'b1, 8'h00);
		bus(4'h0, 1'b0, 8'h00);
		check("save held", 8'h01, q);
		poll(4'h0, 8'h00);
		wait_clk(5'h1f, 5'h17);
	endtask : immediate_save
	task automatic low_osc_gate;
		low_en <= 1'b0;
		bus(4'h0, 1'b1, 8'h01);
		repeat (20) @(posedge sys_clk);
		bus(4'h0, 1'b0, 8'h00);
		check("save refused", 8'h00, q);
		wait_clk(5'h1f, 5'h17);
		low_en <= 1'b1;
		poll(4'h0, 8'h01);
		bus(4'h0, 1'b1, 8'h00);
		poll(4'h0, 8'h00);
	endtask : low_osc_gate
	task automatic gated_save_wake;
		bus(4'h0, 1'b1, 8'h39);
		bus(4'h0, 1'b0, 8'h00);
		check("gated save set", 8'h39, q);
		check("clocks before wait", 8'h17, {3'h0, clk_ctrl});
		pulse(0);
		wait_clk(5'h1f, 5'h1c);
		pulse(1);
		wait_clk(5'h1f, 5'h17);
		bus(4'h0, 1'b0, 8'h00);
		check("wake clears bits", 8'h08, q);
	endtask : gated_save_wake
	task automatic deep_modes;
		for (int i = 1; i <= 2; i++) begin
			bus(4'h0, 1'b1, 8'h38 | (8'h01 << i));
			pulse(0);
			wait_clk(5'h17, {2'h0, i == 1, 2'h0});
			bus(4'h0, 1'b0, 8'h00);
			check("deep mode bits", 8'h38 | (8'h01 << i), q);
			pulse(i);
			wait_clk(5'h1f, 5'h17);
			bus(4'h0, 1'b0, 8'h00);
			check("deep mode exit", 8'h08, q);
		end
		bus(4'h0, 1'b1, 8'h00);
	endtask : deep_modes
	task automatic pll_powerdown;
		bus(4'h8, 1'b1, 8'h01);
		wait_clk(5'h1f, 5'h16);
		poll(4'h4, 8'h07);
		bus(4'h8, 1'b1, 8'h00);
		wait_clk(5'h1f, 5'h17);
	endtask : pll_powerdown
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		reset_values();
		immediate_save();
		low_osc_gate();
		gated_save_wake();
		deep_modes();
		pll_powerdown();
		report_and_stop();
	end
endmodule : test_power_manager
